// ---- hdl/pvrs_host.v ----
// Host controller that configures the preview output and scaler stages
`include "pvrs_regs.vh"
`default_nettype none

module pvrs_fifo #(
	parameter WIDTH = `PVRS_FIFO_WIDTH,
	parameter DEPTH = `PVRS_FIFO_DEPTH,
	parameter AW    = `PVRS_FIFO_AW
) (
	input  wire             clk_sys,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	assign empty     = (wr_q == rd_q);
	assign full      = (wr_q[AW] != rd_q[AW]) &&
		(wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];
	always @(posedge clk_sys) begin
		if (in_valid && !full)
			mem[wr_q[AW-1:0]] <= in_data;
	end
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (in_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (out_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// Function
// R1: Drive contrast gain U8Q4 and brightness offset U8Q0 to the luma stage.
// R2: Device averages chroma pairs to 4:2:2; host only feeds interleaved pixels.
// R3: Clip limits reset to max ffh and min 0, meaning no clipping.
// R4: Drive separate preview-to-scaler and preview-to-memory enables.
// R5: Preview write base and line pitch forced to 32-byte multiples.
// R6: Drive one of four output byte orders to the device.
// R7: Device trims edges per enabled function; host exposes no override.
// R8: Device scales 0.25x to 4x, horizontal then vertical.
// R9: Drive source select; scaler output always goes to memory.
// R10: Reject scaler input width below 32 pixels.
// R11: Stream pixels with hsync and vsync marking line and frame ends.
// R12: Reject start offset plus size exceeding the upstream frame size; the code checks this in streaming mode only.
// R13: Streaming mode drives scaler read base and row pitch as zero.
// R14: Enable only one upstream port toward the scaler.
// R15: Sensor feeding scaler requires sensor YUV 4:2:2 output enabled.
// R16: Memory mode: start column 0-15 or 0-31, start row zero.
// R17: Memory mode drives the programmed read row pitch.
// R18: Memory mode may select color-separate 8-bit input type.
// R19: Streaming mode forces interleaved YUV422 input type.
// R20: Drive luma-first or chroma-first order bit.
// R21: Scaler addresses and pitches forced to 32-byte alignment.
// R22: Reject odd output width or width below 16.
// R23: Reject width over 1280, or over 640 when vertical ratio exceeds 512.
// R24: Reject ratio settings outside 64 to 1024.
module pvrs_host (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire        cfg_apply,
	input  wire [7:0]  cfg_gain,
	input  wire [7:0]  cfg_offset,
	input  wire [31:0] cfg_clip,
	input  wire        cfg_to_scaler,
	input  wire        cfg_to_memory,
	input  wire        cfg_sensor_feeds,
	input  wire [31:0] cfg_prev_base,
	input  wire [31:0] cfg_prev_pitch,
	input  wire [1:0]  cfg_byte_order,
	input  wire        cfg_source,
	input  wire        cfg_type,
	input  wire        cfg_yc_order,
	input  wire [10:0] cfg_hrsz,
	input  wire [10:0] cfg_vrsz,
	input  wire [12:0] cfg_in_width,
	input  wire [12:0] cfg_in_height,
	input  wire [12:0] cfg_start_col,
	input  wire [12:0] cfg_start_row,
	input  wire [12:0] cfg_frame_width,
	input  wire [12:0] cfg_frame_height,
	input  wire [31:0] cfg_read_base,
	input  wire [31:0] cfg_read_pitch,
	input  wire [12:0] cfg_out_width,
	input  wire [31:0] cfg_write_base,
	input  wire [31:0] cfg_write_pitch,
	output reg         cfg_accepted,
	output reg         cfg_rejected,
	output reg  [7:0]  luma_contrast_gain,
	output reg  [7:0]  luma_brightness_offset,
	output reg  [31:0] output_clip_limits,
	output reg         preview_to_scaler_enable,
	output reg         preview_to_memory_enable,
	output reg         sensor_ctrl_to_scaler_enable,
	output reg         sensor_yuv_output_enable,
	output reg  [31:0] preview_write_base,
	output reg  [31:0] preview_write_line_pitch,
	output reg  [1:0]  preview_output_byte_order,
	output reg         scaler_source_select,
	output reg         scaler_input_type,
	output reg         scaler_luma_chroma_order,
	output reg  [10:0] horizontal_ratio_setting,
	output reg  [10:0] vertical_ratio_setting,
	output reg  [12:0] scaler_input_width,
	output reg  [12:0] scaler_input_height,
	output reg  [12:0] scaler_start_column,
	output reg  [12:0] scaler_start_row,
	output reg  [31:0] scaler_read_base,
	output reg  [31:0] scaler_read_row_pitch,
	output reg  [12:0] scaler_output_width,
	output reg  [31:0] scaler_write_base,
	output reg  [31:0] scaler_write_row_pitch,
	input  wire [15:0] pix_data,
	input  wire        pix_line_end,
	input  wire        pix_frame_end,
	input  wire        pix_valid,
	output wire        pix_ready,
	output reg  [15:0] strm_data,
	output reg         strm_valid,
	output reg         strm_hsync,
	output reg         strm_vsync,
	input  wire        strm_stall
);
	wire        stream;
	wire        ratio_bad;
	wire        width_bad;
	wire        window_bad;
	wire        start_bad;
	wire        cfg_bad;
	wire [13:0] col_end;
	wire [13:0] row_end;
	wire [12:0] out_max;
	wire [4:0]  col_max;
	wire [17:0] fifo_out;
	wire        fifo_valid;
	wire        fifo_take;

	function [31:0] align32;
		input [31:0] a;
		align32 = {a[31:`PVRS_ALIGN_BITS], `PVRS_ALIGN_ZERO};
	endfunction

	function ratio_ok;
		input [10:0] r;
		ratio_ok = (r >= `PVRS_RATIO_MIN) && (r <= `PVRS_RATIO_MAX);
	endfunction

	assign stream    = (cfg_source == `PVRS_SRC_STREAM);
	assign ratio_bad = !ratio_ok(cfg_hrsz) || !ratio_ok(cfg_vrsz); // R24
	assign out_max   = (cfg_vrsz <= `PVRS_VRSZ_WIDE_MAX) ?
		`PVRS_MAX_OUT_WIDE : `PVRS_MAX_OUT_NARROW; // R23
	assign width_bad = (cfg_in_width < `PVRS_MIN_IN_WIDTH) || // R10
		cfg_out_width[0] || (cfg_out_width < `PVRS_MIN_OUT_WIDTH) || // R22
		(cfg_out_width > out_max); // R23
	assign col_end   = {1'b0, cfg_start_col} + {1'b0, cfg_in_width};
	assign row_end   = {1'b0, cfg_start_row} + {1'b0, cfg_in_height};
	assign window_bad = stream &&
		((col_end > {1'b0, cfg_frame_width}) ||
		(row_end > {1'b0, cfg_frame_height})); // R12
	assign col_max   = (cfg_type == `PVRS_TYPE_SEPARATE) ?
		`PVRS_COL_MAX_SEP : `PVRS_COL_MAX_YUV;
	assign start_bad = !stream && ((cfg_start_col > {8'h00, col_max}) ||
		(cfg_start_row != 13'h0000)); // R16
	assign cfg_bad   = ratio_bad || width_bad || window_bad || start_bad;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_accepted                 <= 1'b0;
			cfg_rejected                 <= 1'b0;
			luma_contrast_gain           <= `PVRS_GAIN_UNITY;
			luma_brightness_offset       <= 8'h00;
			output_clip_limits           <= {`PVRS_CLIP_MAX_RST,
				`PVRS_CLIP_MAX_RST, `PVRS_CLIP_MIN_RST,
				`PVRS_CLIP_MIN_RST}; // R3
			preview_to_scaler_enable     <= 1'b0;
			preview_to_memory_enable     <= 1'b0;
			sensor_ctrl_to_scaler_enable <= 1'b0;
			sensor_yuv_output_enable     <= 1'b0;
			preview_write_base           <= 32'h00000000;
			preview_write_line_pitch     <= 32'h00000000;
			preview_output_byte_order    <= 2'h0;
			scaler_source_select         <= `PVRS_SRC_STREAM;
			scaler_input_type            <= `PVRS_TYPE_YUV422;
			scaler_luma_chroma_order     <= 1'b0;
			horizontal_ratio_setting     <= `PVRS_RATIO_RST;
			vertical_ratio_setting       <= `PVRS_RATIO_RST;
			scaler_input_width           <= 13'h0000;
			scaler_input_height          <= 13'h0000;
			scaler_start_column          <= 13'h0000;
			scaler_start_row             <= 13'h0000;
			scaler_read_base             <= 32'h00000000;
			scaler_read_row_pitch        <= 32'h00000000;
			scaler_output_width          <= 13'h0000;
			scaler_write_base            <= 32'h00000000;
			scaler_write_row_pitch       <= 32'h00000000;
		end else begin
			cfg_accepted <= cfg_apply && !cfg_bad;
			cfg_rejected <= cfg_apply && cfg_bad;
			if (cfg_apply && !cfg_bad) begin
				luma_contrast_gain        <= cfg_gain; // R1
				luma_brightness_offset    <= cfg_offset; // R1
				output_clip_limits        <= cfg_clip; // R3
				preview_to_memory_enable  <= cfg_to_memory; // R4
				preview_to_scaler_enable  <= cfg_to_scaler &&
					!(stream && cfg_sensor_feeds); // R14
				sensor_ctrl_to_scaler_enable <= stream &&
					cfg_sensor_feeds; // R14
				sensor_yuv_output_enable  <= stream &&
					cfg_sensor_feeds; // R15
				preview_write_base        <= align32(cfg_prev_base); // R5
				preview_write_line_pitch  <= align32(cfg_prev_pitch); // R5
				preview_output_byte_order <= cfg_byte_order; // R6
				scaler_source_select      <= cfg_source; // R9
				scaler_input_type         <= stream ?
					`PVRS_TYPE_YUV422 : cfg_type; // R19 R18
				scaler_luma_chroma_order  <= cfg_yc_order; // R20
				horizontal_ratio_setting  <= cfg_hrsz; // R8
				vertical_ratio_setting    <= cfg_vrsz; // R8
				scaler_input_width        <= cfg_in_width;
				scaler_input_height       <= cfg_in_height;
				scaler_start_column       <= cfg_start_col; // R12 R16
				scaler_start_row          <= cfg_start_row; // R12 R16
				scaler_read_base          <= stream ? 32'h00000000 :
					align32(cfg_read_base); // R13 R21
				scaler_read_row_pitch     <= stream ? 32'h00000000 :
					align32(cfg_read_pitch); // R13 R17
				scaler_output_width       <= cfg_out_width;
				scaler_write_base         <= align32(cfg_write_base); // R21
				scaler_write_row_pitch    <= align32(cfg_write_pitch); // R21
			end
		end
	end

	// Pixel path buffered so the device can stall the source
	pvrs_fifo #(
		.WIDTH (`PVRS_FIFO_WIDTH),
		.DEPTH (`PVRS_FIFO_DEPTH),
		.AW    (`PVRS_FIFO_AW)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset_n   (reset_n),
		.in_data   ({pix_frame_end, pix_line_end, pix_data}),
		.in_valid  (pix_valid),
		.in_ready  (pix_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_valid),
		.out_ready (fifo_take)
	);

	assign fifo_take = !strm_stall;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strm_data  <= 16'h0000;
			strm_valid <= 1'b0;
			strm_hsync <= 1'b0;
			strm_vsync <= 1'b0;
		end else if (!strm_stall) begin
			strm_valid <= fifo_valid;
			strm_data  <= fifo_valid ? fifo_out[`PVRS_DATA_MSB:0] :
				strm_data;
			strm_hsync <= fifo_valid && fifo_out[`PVRS_LINE_BIT]; // R11
			strm_vsync <= fifo_valid && fifo_out[`PVRS_FRAME_BIT]; // R11
		end
	end
endmodule

`default_nettype wire

// ---- hdl/pvrs_regs.vh ----
// Constants for the preview and scaler host controller
`ifndef PVRS_REGS_VH
`define PVRS_REGS_VH
`define PVRS_ALIGN_BITS     5
`define PVRS_ALIGN_ZERO     5'h00
`define PVRS_MIN_IN_WIDTH   13'h0020
`define PVRS_MIN_OUT_WIDTH  13'h0010
`define PVRS_MAX_OUT_WIDE   13'h0500
`define PVRS_MAX_OUT_NARROW 13'h0280
`define PVRS_VRSZ_WIDE_MAX  11'h200
`define PVRS_RATIO_MIN      11'h040
`define PVRS_RATIO_MAX      11'h400
`define PVRS_RATIO_RST      11'h100
`define PVRS_COL_MAX_YUV    5'h0f
`define PVRS_COL_MAX_SEP    5'h1f
`define PVRS_SRC_STREAM     1'b0
`define PVRS_SRC_MEMORY     1'b1
`define PVRS_TYPE_YUV422    1'b0
`define PVRS_TYPE_SEPARATE  1'b1
`define PVRS_CLIP_MAX_RST   8'hff
`define PVRS_CLIP_MIN_RST   8'h00
`define PVRS_GAIN_UNITY     8'h10
`define PVRS_FIFO_WIDTH     18
`define PVRS_FIFO_DEPTH     32
`define PVRS_FIFO_AW        5
`define PVRS_DATA_MSB       15
`define PVRS_LINE_BIT       16
`define PVRS_FRAME_BIT      17
`endif

// ---- sim/pvrs_dev_model.sv ----
// Device side model: takes the scaler stream and may stall it
`default_nettype none
module pvrs_dev_model (
	input  wire logic        clk_sys,
	input  wire logic        hold,
	input  wire logic        slow,
	input  wire logic [15:0] strm_data,
	input  wire logic        strm_valid,
	input  wire logic        strm_hsync,
	input  wire logic        strm_vsync,
	output var  logic        strm_stall
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [17:0] rx[$];
	logic        tick = 1'b0;
	// Slow mode stalls every other cycle
	assign strm_stall = hold | (slow & tick);
	always @(posedge clk_sys) begin
		tick <= ~tick;
		// Line and frame ends travel with the pixel
		if (strm_valid && !strm_stall)
			rx.push_back({strm_vsync, strm_hsync, strm_data});
	end
endmodule
`default_nettype wire

// ---- sim/pvrs_host_bench.sv ----
// Bench for the preview and scaler host controller
`default_nettype none
module pvrs_host_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, reset_n, cfg_apply, cfg_to_scaler, cfg_to_memory;
	logic cfg_sensor_feeds, cfg_source, cfg_type, cfg_yc_order, hold, slow;
	logic [7:0] cfg_gain, cfg_offset;
	logic [1:0] cfg_byte_order;
	logic [10:0] cfg_hrsz, cfg_vrsz;
	logic [12:0] cfg_in_width, cfg_in_height, cfg_start_col, cfg_start_row;
	logic [12:0] cfg_frame_width, cfg_frame_height, cfg_out_width;
	logic [31:0] cfg_clip, cfg_prev_base, cfg_prev_pitch, cfg_read_base;
	logic [31:0] cfg_read_pitch, cfg_write_base, cfg_write_pitch;
	logic [15:0] pix_data;
	logic pix_line_end, pix_frame_end, pix_valid;
	wire logic cfg_accepted, cfg_rejected, preview_to_scaler_enable;
	wire logic preview_to_memory_enable, sensor_ctrl_to_scaler_enable;
	wire logic sensor_yuv_output_enable, scaler_source_select;
	wire logic scaler_input_type, scaler_luma_chroma_order, pix_ready;
	wire logic strm_valid, strm_hsync, strm_vsync, strm_stall;
	wire logic [7:0] luma_contrast_gain, luma_brightness_offset;
	wire logic [1:0] preview_output_byte_order;
	wire logic [10:0] horizontal_ratio_setting, vertical_ratio_setting;
	wire logic [12:0] scaler_input_width, scaler_input_height;
	wire logic [12:0] scaler_start_column, scaler_start_row;
	wire logic [12:0] scaler_output_width;
	wire logic [31:0] output_clip_limits, preview_write_base;
	wire logic [31:0] preview_write_line_pitch, scaler_read_base;
	wire logic [31:0] scaler_read_row_pitch, scaler_write_base;
	wire logic [31:0] scaler_write_row_pitch;
	wire logic [15:0] strm_data;
	int error_cnt = 0;
	int num_checks = 0;
	pvrs_host i_dut (.*);
	pvrs_dev_model i_model (.*);
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic base(input logic [7:0] g);
		{cfg_gain, cfg_offset, cfg_clip} <= {g, 8'h07, 32'hf0e01008};
		{cfg_to_scaler, cfg_to_memory, cfg_sensor_feeds, cfg_source,
			cfg_type, cfg_yc_order, cfg_byte_order} <= 8'h10;
		{cfg_prev_base, cfg_prev_pitch, cfg_read_base, cfg_read_pitch} <=
			{32'h10000013, 32'h00000285, 32'h2000001f, 32'h00000505};
		{cfg_write_base, cfg_write_pitch, cfg_hrsz, cfg_vrsz} <=
			{32'h3000000a, 32'h00000141, 11'h100, 11'h100};
		{cfg_in_width, cfg_in_height, cfg_start_col, cfg_start_row} <=
			{13'h0040, 13'h0030, 13'h0000, 13'h0000};
		{cfg_frame_width, cfg_frame_height, cfg_out_width} <=
			{13'h0280, 13'h01e0, 13'h0040};
		@(posedge clk_sys);
	endtask
	task automatic app(input logic ok);
		cfg_apply <= 1'b1;
		@(posedge clk_sys);
		cfg_apply <= 1'b0;
		#1;
		chk({cfg_accepted, cfg_rejected}, {ok, !ok});
		if (!ok)
			chk(luma_contrast_gain, 8'h23);
		@(posedge clk_sys);
	endtask
	task automatic tryc(input logic [12:0] inw, outw, col,
		input logic [10:0] hr, vr, input logic [1:0] st, input logic ok);
		base(ok ? 8'h23 : 8'h55);
		{cfg_in_width, cfg_out_width, cfg_start_col} <= {inw, outw, col};
		{cfg_hrsz, cfg_vrsz, cfg_source, cfg_type} <= {hr, vr, st};
		app(ok);
	endtask
	task automatic push(input int i);
		logic r;
		{pix_valid, pix_frame_end, pix_line_end, pix_data} <=
			{1'b1, i == 39, i[2:0] == 3'h7, 16'ha500 + i[15:0]};
		do begin
			@(negedge clk_sys);
			r = pix_ready;
			@(posedge clk_sys);
		end while (!r);
	endtask
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	initial begin
		{reset_n, cfg_apply, pix_valid, hold, slow} = 5'h02;
		base(8'h23);
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		chk({luma_contrast_gain, horizontal_ratio_setting}, 19'h08100);
		chk(output_clip_limits, 32'hffff0000);
		chk(pix_ready, 1'b1);
		for (int k = 0; k < 4; k++) begin
			base(8'h23);
			{cfg_to_memory, cfg_to_scaler, cfg_byte_order, cfg_yc_order} <=
				{k[1:0], k[1:0], k[0]};
			app(1'b1);
			chk(preview_output_byte_order, k[1:0]);
			chk(scaler_luma_chroma_order, k[0]);
			chk({preview_to_memory_enable, preview_to_scaler_enable}, k[1:0]);
		end
		chk({luma_contrast_gain, luma_brightness_offset}, 16'h2307);
		chk(output_clip_limits, 32'hf0e01008);
		chk(scaler_read_base, 32'h20000000);
		chk(scaler_read_row_pitch, 32'h00000500);
		chk(scaler_write_row_pitch, 32'h00000140);
		chk(scaler_write_base, 32'h30000000);
		chk(preview_write_base, 32'h10000000);
		chk(preview_write_line_pitch, 32'h00000280);
		chk({scaler_input_width, scaler_input_height}, 26'h0080030);
		chk({scaler_output_width, scaler_start_row}, 26'h0080000);
		chk(scaler_source_select, 1'b1);
		base(8'h23);
		{cfg_source, cfg_type, cfg_sensor_feeds, cfg_to_scaler} <= 4'h7;
		app(1'b1);
		chk(scaler_read_base | scaler_read_row_pitch, 32'h0);
		chk({scaler_input_type, sensor_ctrl_to_scaler_enable,
			sensor_yuv_output_enable, preview_to_scaler_enable}, 4'h6);
		tryc(13'h01f, 13'h040, 13'h000, 11'h100, 11'h100, 2'h2, 1'b0);
		tryc(13'h040, 13'h041, 13'h000, 11'h100, 11'h100, 2'h2, 1'b0);
		tryc(13'h040, 13'h00e, 13'h000, 11'h100, 11'h100, 2'h2, 1'b0);
		tryc(13'h040, 13'h502, 13'h000, 11'h100, 11'h200, 2'h2, 1'b0);
		tryc(13'h040, 13'h282, 13'h000, 11'h100, 11'h201, 2'h2, 1'b0);
		tryc(13'h040, 13'h280, 13'h000, 11'h100, 11'h201, 2'h2, 1'b1);
		tryc(13'h040, 13'h040, 13'h000, 11'h03f, 11'h100, 2'h2, 1'b0);
		tryc(13'h040, 13'h040, 13'h000, 11'h400, 11'h040, 2'h2, 1'b1);
		chk({horizontal_ratio_setting, vertical_ratio_setting}, 22'h200040);
		tryc(13'h040, 13'h040, 13'h241, 11'h100, 11'h100, 2'h0, 1'b0);
		tryc(13'h040, 13'h040, 13'h240, 11'h100, 11'h100, 2'h0, 1'b1);
		tryc(13'h040, 13'h040, 13'h010, 11'h100, 11'h100, 2'h2, 1'b0);
		tryc(13'h040, 13'h040, 13'h01f, 11'h100, 11'h100, 2'h3, 1'b1);
		chk({scaler_start_column, scaler_input_type}, 14'h003f);
		base(8'h55);
		{cfg_source, cfg_start_row} <= {1'b0, 13'h01b1};
		app(1'b0);
		base(8'h55);
		cfg_start_row <= 13'h0001;
		app(1'b0);
		fork
			for (int i = 0; i < 40; i++)
				push(i);
			begin
				repeat (60) @(posedge clk_sys);
				@(negedge clk_sys);
				chk(pix_ready, 1'b0);
				@(posedge clk_sys);
				{hold, slow} <= 2'h1;
			end
		join
		pix_valid <= 1'b0;
		repeat (200) @(posedge clk_sys);
		chk(i_model.rx.size(), 40);
		for (int i = 0; i < 40; i++)
			chk(i_model.rx[i], {i == 39, i[2:0] == 3'h7, 16'ha500 + i[15:0]});
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- sim/pvrs_host_properties.sv ----
// Assertions on the host controller ports
`default_nettype none
module pvrs_host_props (
	input wire logic        clk_sys,
	input wire logic        reset_n,
	input wire logic        cfg_apply,
	input wire logic [7:0]  cfg_gain,
	input wire logic [10:0] cfg_hrsz,
	input wire logic [10:0] cfg_vrsz,
	input wire logic [12:0] cfg_in_width,
	input wire logic [12:0] cfg_out_width,
	input wire logic        cfg_accepted,
	input wire logic        cfg_rejected,
	input wire logic [7:0]  luma_contrast_gain,
	input wire logic        scaler_source_select,
	input wire logic [31:0] scaler_read_base,
	input wire logic [15:0] strm_data,
	input wire logic        strm_valid,
	input wire logic        strm_stall
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_take;
		cfg_apply ##1 cfg_accepted;
	endsequence
	AST_ANSWER: assert property (cfg_apply |=> cfg_accepted ^ cfg_rejected)
		else $error("apply not answered");
	AST_QUIET: assert property (!cfg_apply |=> !cfg_accepted && !cfg_rejected)
		else $error("answer without apply");
	AST_GAIN: assert property (
		s_take |-> luma_contrast_gain == $past(cfg_gain))
		else $error("gain not taken");
	AST_IN_WIDTH: assert property (
		cfg_apply && cfg_in_width < 13'h0020 |=> cfg_rejected)
		else $error("narrow input taken");
	AST_OUT_WIDTH: assert property (
		cfg_apply && (cfg_out_width[0] || cfg_out_width < 13'h0010)
		|=> cfg_rejected)
		else $error("bad output width taken");
	AST_NARROW: assert property (
		cfg_apply && cfg_vrsz > 11'h200 && cfg_out_width > 13'h0280
		|=> cfg_rejected)
		else $error("wide output taken");
	AST_RATIO: assert property (
		cfg_apply && (cfg_hrsz < 11'h040 || cfg_hrsz > 11'h400)
		|=> cfg_rejected)
		else $error("bad ratio taken");
	AST_STREAM: assert property (
		cfg_accepted && !scaler_source_select |-> scaler_read_base == 32'h0)
		else $error("stream read base not zero");
	AST_HOLD: assert property (
		strm_valid && strm_stall |=> strm_valid && $stable(strm_data))
		else $error("stream moved under stall");
endmodule
bind pvrs_host pvrs_host_props i_props (.*);
`default_nettype wire
